// File: hdl/fsr_defs.vh
`ifndef FSR_DEFS_VH
`define FSR_DEFS_VH
// Register word offsets (byte address = 4 * index)
`define FSR_IDX_STATUS     3'h0
`define FSR_IDX_IRQ_EN     3'h1
`define FSR_IDX_IRQ_FLAGS  3'h2
`define FSR_IDX_IRQ_CLEAR  3'h3
`define FSR_IDX_TRIM       3'h4
// Status bit positions
`define FSR_ST_DONE        0
`define FSR_ST_STALL       1
`define FSR_ST_CHIP_ERASE  2
`define FSR_ST_SUSPEND     3
`define FSR_ST_SECT_ERASE  4
`define FSR_ST_PROGRAM     5
// Flag, enable and clear bit positions
`define FSR_BIT_DONE       0
`define FSR_BIT_STALL      1
// Trim mirror fields
`define FSR_TEMP_LSB       16
`define FSR_TEMP_W         5
`define FSR_FREQ_LSB       0
`define FSR_FREQ_W         10
// Trim word locations in flash
`define FSR_FREQ_TRIM_ADDR 32'h0010_1004
`define FSR_TEMP_TRIM_ADDR 32'h0010_1006
// Reset values
`define FSR_EN_RESET       2'h0
`define FSR_FLAG_RESET     2'h0
`define FSR_TRIM_RESET     32'h0000_0000
`endif

// File: hdl/fsr_edge.v
`timescale 1ns/10ps
// Rising edge detector per bit
module fsr_edge #(
    parameter W = 2
) (
    input  wire         clk,
    input  wire         reset,
    input  wire [W-1:0] level_in,
    output wire [W-1:0] rise
);
    reg [W-1:0] prev_r;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk or posedge reset) begin
                if (reset)
                    prev_r[i] <= 1'b0;
                else
                    prev_r[i] <= level_in[i];
            end
            assign rise[i] = level_in[i] & ~prev_r[i];
        end
    endgenerate
endmodule

// File: hdl/fsr_trim_load.v
`timescale 1ns/10ps
`include "fsr_defs.vh"
// Fetches the two trim words from flash once after reset release
module fsr_trim_load (
    input  wire        clk,
    input  wire        reset,
    output reg         fl_rd_r,
    output reg  [31:0] fl_addr_r,
    input  wire        fl_ack,
    input  wire [15:0] fl_rdata,
    output reg  [31:0] trim_r
);
    localparam S_FREQ = 2'h0;
    localparam S_TEMP = 2'h1;
    localparam S_DONE = 2'h2;
    reg [1:0] state_r;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r   <= S_FREQ;
            fl_rd_r   <= 1'b0;
            fl_addr_r <= 32'h0000_0000;
            trim_r    <= `FSR_TRIM_RESET;
        end else begin
            case (state_r)
                S_FREQ: begin
                    fl_rd_r   <= 1'b1;
                    fl_addr_r <= `FSR_FREQ_TRIM_ADDR;
                    if (fl_rd_r && fl_ack) begin
                        trim_r[`FSR_FREQ_LSB +: `FSR_FREQ_W] <= fl_rdata[`FSR_FREQ_W-1:0];
                        fl_addr_r <= `FSR_TEMP_TRIM_ADDR;
                        state_r   <= S_TEMP;
                    end
                end
                S_TEMP: begin
                    if (fl_ack) begin
                        trim_r[`FSR_TEMP_LSB +: `FSR_TEMP_W] <= fl_rdata[`FSR_TEMP_W-1:0];
                        fl_rd_r <= 1'b0;
                        state_r <= S_DONE;
                    end
                end
                S_DONE: begin
                    fl_rd_r <= 1'b0;
                end
                default: begin
                    state_r <= S_DONE;
                    fl_rd_r <= 1'b0;
                end
            endcase
        end
    end
endmodule

// File: hdl/fsr_regs.v
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`include "fsr_defs.vh"
module fsr_regs (
    input  wire        clk,
    input  wire        reset,
    // Avalon-MM slave
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg  [1:0]  avs_response,
    // Status from the flash automatic algorithm, asynchronous to clk
    input  wire        alg_done,
    input  wire        alg_stall,
    input  wire        alg_chip_erase,
    input  wire        alg_sector_erase,
    input  wire        alg_suspended,
    input  wire        alg_program,
    // Flash read port for the trim fetch
    output reg         fl_rd_r,
    output reg  [31:0] fl_addr_r,
    input  wire        fl_ack,
    input  wire [15:0] fl_rdata,
    // Interrupt to the CPU
    output reg         irq_r
);
    localparam [1:0] RESP_OK    = 2'h0;
    localparam [1:0] RESP_DECERR = 2'h3;

    // Two-stage synchronisers for the algorithm status levels
    reg  [5:0] sync1_r;
    reg  [5:0] sync2_r;
    wire [5:0] raw_status;
    assign raw_status = {alg_program, alg_sector_erase, alg_suspended,
                         alg_chip_erase, alg_stall, alg_done};
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
        end else begin
            sync1_r <= raw_status;
            sync2_r <= sync1_r;
        end
    end

    // Status register image, ready bit follows the synchronised level
    reg  [7:0] status_r;
    always @(posedge clk or posedge reset) begin
        if (reset)
            status_r <= 8'h00;
        else begin
            status_r <= 8'h00;
            status_r[`FSR_ST_DONE]       <= sync2_r[0];
            status_r[`FSR_ST_STALL]      <= sync2_r[1];
            status_r[`FSR_ST_CHIP_ERASE] <= sync2_r[2];
            status_r[`FSR_ST_SUSPEND]    <= sync2_r[3];
            status_r[`FSR_ST_SECT_ERASE] <= sync2_r[4];
            status_r[`FSR_ST_PROGRAM]    <= sync2_r[5];
        end
    end

    // Edge detection on stall and ready
    wire [1:0] evt_rise;
    fsr_edge #(
        .W (2)
    ) u_edge (
        .clk      (clk),
        .reset    (reset),
        .level_in ({sync2_r[1], sync2_r[0]}),
        .rise     (evt_rise)
    );

    // Trim mirror fetch
    wire        trim_rd;
    wire [31:0] trim_addr;
    wire [31:0] trim_val;
    fsr_trim_load u_trim (
        .clk       (clk),
        .reset     (reset),
        .fl_rd_r   (trim_rd),
        .fl_addr_r (trim_addr),
        .fl_ack    (fl_ack),
        .fl_rdata  (fl_rdata),
        .trim_r    (trim_val)
    );
    // Pass the loader's own flops straight out; an extra stage would pair acks with a stale address
    always @* begin
        fl_rd_r   = trim_rd;
        fl_addr_r = trim_addr;
    end

    // Bus decode; one wait cycle so every access answers on the second edge
    reg        busy_r;
    wire       req;
    wire       take;
    wire [2:0] idx;
    wire       mapped;
    assign req    = avs_read | avs_write;
    assign take   = req & ~busy_r;
    assign idx    = avs_address[4:2];
    assign mapped = (idx <= `FSR_IDX_TRIM);

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_r          <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            busy_r          <= req & ~busy_r;
            avs_waitrequest <= ~(req & ~busy_r);
        end
    end

    wire wr_fire;
    assign wr_fire = avs_write & ~avs_waitrequest;

    // Enable register
    reg [1:0] irq_en_r;
    always @(posedge clk or posedge reset) begin
        if (reset)
            irq_en_r <= `FSR_EN_RESET;
        else if (wr_fire && idx == `FSR_IDX_IRQ_EN && avs_byteenable[0])
            irq_en_r <= avs_writedata[1:0];
    end

    // Event flags: a rising edge in the clear cycle wins over the clear
    reg  [1:0] flag_r;
    reg  [1:0] flag_nxt;
    wire [1:0] clr;
    assign clr = (wr_fire && idx == `FSR_IDX_IRQ_CLEAR && avs_byteenable[0]) ?
                 avs_writedata[1:0] : 2'h0;
    always @* begin
        flag_nxt = flag_r & ~clr;
        flag_nxt[`FSR_BIT_STALL] = flag_nxt[`FSR_BIT_STALL] | evt_rise[1];
        flag_nxt[`FSR_BIT_DONE]  = flag_nxt[`FSR_BIT_DONE] | evt_rise[0];
    end
    always @(posedge clk or posedge reset) begin
        if (reset)
            flag_r <= `FSR_FLAG_RESET;
        else
            flag_r <= flag_nxt;
    end

    // Level interrupt, held until flags cleared or enables dropped
    always @(posedge clk or posedge reset) begin
        if (reset)
            irq_r <= 1'b0;
        else
            irq_r <= |(flag_r & irq_en_r);
    end

    // Read data; reserved bits and the clear register read zero
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (idx)
            `FSR_IDX_STATUS:    rd_mux = {24'h000000, status_r};
            `FSR_IDX_IRQ_EN:    rd_mux = {30'h0, irq_en_r};
            `FSR_IDX_IRQ_FLAGS: rd_mux = {30'h0, flag_r};
            `FSR_IDX_IRQ_CLEAR: rd_mux = 32'h0000_0000;
            `FSR_IDX_TRIM:      rd_mux = trim_val;
            default:            rd_mux = 32'h0000_0000;
        endcase
    end
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= RESP_OK;
        end else if (take) begin
            avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
            avs_response <= mapped ? RESP_OK : RESP_DECERR;
        end
    end
endmodule

// File: tb/fsr_regs_monitor.sv
`timescale 1ns/10ps
module fsr_regs_monitor (
    input logic        clk,
    input logic        reset,
    input logic [4:0]  avs_address,
    input logic        avs_read,
    input logic        avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0]  avs_byteenable,
    input logic [31:0] avs_readdata,
    input logic        avs_waitrequest,
    input logic [1:0]  avs_response,
    input logic        alg_done,
    input logic        alg_stall,
    input logic        alg_chip_erase,
    input logic        alg_sector_erase,
    input logic        alg_suspended,
    input logic        alg_program,
    input logic        fl_rd_r,
    input logic [31:0] fl_addr_r,
    input logic        fl_ack,
    input logic [15:0] fl_rdata,
    input logic        irq_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire       fin = (avs_read || avs_write) && !avs_waitrequest;
    wire [2:0] idx = avs_address[4:2];
    property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
    property p_answer; (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("access not answered");
    property p_idle; !avs_read && !avs_write |-> avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("waitrequest low while idle");
    property p_decode; avs_read && !avs_waitrequest && idx > 3'h4 |-> avs_response == 2'h3 && avs_readdata == 32'h0; endproperty
    a_decode: assert property (p_decode) else $error("unmapped read not refused");
    property p_ok; fin && idx <= 3'h4 |-> avs_response == 2'h0; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_clr_rd0; avs_read && !avs_waitrequest && idx == 3'h3 |-> avs_readdata == 32'h0; endproperty
    a_clr_rd0: assert property (p_clr_rd0) else $error("clear register read not zero");
    property p_fl_hold; fl_rd_r && !fl_ack |=> fl_rd_r && $stable(fl_addr_r); endproperty
    a_fl_hold: assert property (p_fl_hold) else $error("trim fetch dropped early");
    property p_fl_start; $fell(reset) |-> ##[0:2] fl_rd_r && fl_addr_r == 32'h0010_1004; endproperty
    a_fl_start: assert property (p_fl_start) else $error("trim fetch not started");
    property p_irq_clr;
        fin && avs_write && idx == 3'h3 && avs_writedata[1:0] == 2'h3 && !alg_done && !alg_stall |-> ##[1:3] !irq_r;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq kept after clear");
    property p_irq_dis; fin && avs_write && idx == 3'h1 && avs_writedata[1:0] == 2'h0 |-> ##[1:3] !irq_r; endproperty
    a_irq_dis: assert property (p_irq_dis) else $error("irq kept while disabled");
    c_decode: cover property (avs_read && !avs_waitrequest && idx > 3'h4);
    c_irq: cover property ($rose(irq_r));
    c_fetch: cover property (fl_rd_r && fl_ack);
endmodule
bind fsr_regs fsr_regs_monitor u_mon (.*);

// File: tb/flash_status_irq_regs_tb.sv
`timescale 1ns/10ps
module flash_status_irq_regs_tb;
    logic        clk, reset, avs_read, avs_write, avs_waitrequest, fl_rd_r, fl_ack, irq_r, erased;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, fl_addr_r, rdat, saved;
    logic [1:0]  avs_response, resp;
    logic [15:0] fl_rdata;
    logic [5:0]  alg;
    int          error_cnt, num_checks;
    fsr_regs dut (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .alg_done(alg[0]), .alg_stall(alg[1]), .alg_chip_erase(alg[2]), .alg_suspended(alg[3]),
        .alg_sector_erase(alg[4]), .alg_program(alg[5]), .fl_rd_r(fl_rd_r), .fl_addr_r(fl_addr_r),
        .fl_ack(fl_ack), .fl_rdata(fl_rdata), .irq_r(irq_r));
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    // Flash answers one cycle late; an erased array reads zero here
    always @(posedge clk) begin
        fl_ack <= fl_rd_r && !fl_ack;
        fl_rdata <= erased ? 16'h0 : (fl_addr_r == 32'h0010_1004 ? 16'hfd5a : 16'hffd3);
    end
    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task bus(input logic we, input logic [2:0] i, input logic [31:0] wd);
        int n;
        @(posedge clk);
        avs_address <= {i, 2'b00};
        avs_write <= we;
        avs_read <= !we;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rdat = avs_readdata;
        resp = avs_response;
        avs_read <= 0;
        avs_write <= 0;
        if (n >= 20) begin
            error_cnt++;
            test_done;
        end
    endtask
    task rd(input logic [2:0] i, input string n, input logic [31:0] exp);
        bus(0, i, 0);
        chk(n, rdat, exp);
    endtask
    task wait_irq(input logic exp);
        int n;
        n = 0;
        while (irq_r !== exp && n < 10) begin
            @(posedge clk);
            n++;
        end
        chk("irq", irq_r, exp);
    endtask
    // Status pins pass a synchroniser, so give them a few edges
    task settle;
        repeat (5) @(posedge clk);
    endtask
    task t_reset;
        rd(3'h1, "enable", 32'h0);
        rd(3'h2, "flags", 32'h0);
        rd(3'h0, "status", 32'h0);
        $display("reset test done");
    endtask
    task t_status;
        for (int b = 0; b < 6; b++) begin
            alg <= 6'h1 << b;
            settle;
            bus(0, 3'h4, 0);
            rd(3'h0, "status", 32'h1 << b);
        end
        alg <= 6'h0;
        settle;
        $display("status test done");
    endtask
    task t_irq;
        bus(1, 3'h3, 32'h3);
        bus(1, 3'h1, 32'hff);
        rd(3'h1, "enable", 32'h3);
        wait_irq(0);
        alg <= 6'h2;
        wait_irq(1);
        rd(3'h2, "flags", 32'h2);
        bus(1, 3'h3, 32'h1);
        rd(3'h2, "flags", 32'h2);
        bus(1, 3'h3, 32'h2);
        rd(3'h2, "flags", 32'h0);
        wait_irq(0);
        alg <= 6'h1;
        wait_irq(1);
        rd(3'h2, "flags", 32'h1);
        bus(1, 3'h1, 32'h0);
        wait_irq(0);
        rd(3'h3, "clear", 32'h0);
        alg <= 6'h0;
        settle;
        bus(1, 3'h3, 32'h3);
        rd(3'h2, "flags", 32'h0);
        bus(0, 3'h5, 0);
        chk("response", resp, 2'h3);
        $display("interrupt test done");
    endtask
    task t_trim;
        rd(3'h4, "trim", 32'h0013_015a);
        saved = rdat;
        erased <= 1;
        reset <= 1;
        repeat (4) @(posedge clk);
        reset <= 0;
        repeat (10) @(posedge clk);
        rd(3'h4, "trim", 32'h0);
        chk("saved trim", saved, 32'h0013_015a);
        $display("trim test done");
    endtask
    initial begin
        reset = 1;
        avs_read = 0;
        avs_write = 0;
        avs_address = 0;
        avs_writedata = 0;
        alg = 0;
        fl_ack = 0;
        fl_rdata = 0;
        erased = 0;
        error_cnt = 0;
        num_checks = 0;
        repeat (4) @(posedge clk);
        reset <= 0;
        t_reset;
        t_status;
        t_irq;
        t_trim;
        test_done;
    end
endmodule
